// [bench/lod_prog_mem.sv]
// program memory model handing out operation words and extension words by slot
`timescale 1ns/1ps
module lod_prog_mem
   import lod_pkg::*;
(
   input  wire logic [4:0]  idx,
   output logic      [15:0] opword,
   output logic      [31:0] ext
);
   // ************************************************
   // program image
   // ************************************************
   // register-destination encoding
   // data register targets use the register-destination opmode; slot 8 breaks this on purpose
   localparam logic [15:0] OPS [27] = '{
      16'hC600, 16'hCA50, 16'hC0BC, 16'hC0BB, 16'hC008, 16'hC03D, 16'hC118, 16'hC1B9, 16'hC100,
      16'hC148, 16'hC1BA, 16'hC1BC, 16'hC0C0, 16'hC1C0, 16'h0000, 16'h0078, 16'h00B9, 16'h00C0,
      16'h0008, 16'h003A, 16'h003C, 16'h4600, 16'h4668, 16'h46B9, 16'h4608, 16'h46C0, 16'h4E71};

   // empty slots read an all-ones operation word, so a stale word never passes for a fresh one
   always_comb
   begin
      opword = (idx < 5'd27) ? OPS[idx] : 16'hFFFF;
      case (idx)
         5'd2:    ext = 32'h8000_1234;
         5'd14:   ext = 32'hFF81_0000;  // upper byte of the word is not data
         5'd15:   ext = 32'h8000_FFFF;  // second word is not data at word size
         default: ext = 32'h0000_0000;
      endcase
   end
endmodule // lod_prog_mem

// [bench/tb_logical_or_decode_execute.sv]
// self-checking bench for the logical-or decode/execute block through its register port
`timescale 1ns/1ps
module tb_logical_or_decode_execute
   import lod_pkg::*;
;
   localparam int N = 27;
   localparam logic [31:0] SRCS [N] = '{0: 32'hF0, 2: 32'hFFFF_FFFF, 3: 32'h8000, 6: 32'h5A,
      7: 32'h8000_0000, default: 32'h11};
   localparam logic [31:0] DSTS [N] = '{0: 32'h1234_560F, 1: 32'hABCD_0000, 2: 32'h1, 3: 32'h0,
      6: 32'hFFFF_FF00, 7: 32'h1, 14: 32'h0, 15: 32'h1, 16: 32'h0, 21: 32'h1234_56FF, 22: 32'h0,
      23: 32'h0F0F_0F0F, default: 32'h2222_2222};
   localparam logic [4:0] CCRS [N] = '{0: 5'h1F, 1: 5'h03, 3: 5'h10, 6: 5'h0F, 15: 5'h1F,
      21: 5'h1F, default: 5'h00};

   logic              aclk;
   logic              aresetn;
   logic [ADDR_W-1:0] awaddr;
   logic [ADDR_W-1:0] araddr;
   logic [31:0]       wdata;
   logic [31:0]       rdata;
   logic              awvalid, wvalid, bready, arvalid, rready;
   logic              awready, wready, bvalid, arready, rvalid;
   logic [1:0]        bresp, rresp;
   logic [4:0]        pm_idx;
   logic [15:0]       pm_op;
   logic [31:0]       pm_ext;
   int                failures;
   int                check_count;

   // free-running 10 MHz clock
   initial aclk = 1'b0;
   always #50 aclk = ~aclk;

   lod_core i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

   lod_prog_mem i_prog (.idx(pm_idx), .opword(pm_op), .ext(pm_ext));

   // ************************************************
   // bus tasks
   // ************************************************
   task automatic test_done();
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp)
      begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   // bready stays high between writes so it is never driven twice in one step
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, output logic [1:0] resp);
      int n;
      n = 0;
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do
      begin
         @(posedge aclk);
         n++;
         if (awvalid && awready)
            awvalid <= 1'b0;
         if (wvalid && wready)
            wvalid <= 1'b0;
      end while (bvalid !== 1'b1 && n < 50);
      resp = bresp;
      if (bvalid !== 1'b1)
      begin
         chk("write answer", 32'h1, 32'h0);
         test_done();
      end
   endtask

   task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] resp);
      int n;
      n = 0;
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do
      begin
         @(posedge aclk);
         n++;
         if (arvalid && arready)
            arvalid <= 1'b0;
      end while (rvalid !== 1'b1 && n < 50);
      d = rdata;
      resp = rresp;
      if (rvalid !== 1'b1)
      begin
         chk("read answer", 32'h1, 32'h0);
         test_done();
      end
   endtask

   function automatic logic [ADDR_W-1:0] ad(input logic [5:0] idx);
      return {idx, 2'b00};
   endfunction

   // ************************************************
   // reference model of decode and execution
   // ************************************************
   function automatic void model(input logic [15:0] op, input logic [31:0] ext, src, dst, last,
      input logic [4:0] ci, output logic [31:0] res, output logic [4:0] cc, output logic [9:0] st,
      output logic [9:0] msk);
      logic [2:0]  md, rg;
      logic [1:0]  sz, nw;
      logic [31:0] a, r, imm;
      logic        ok, treg, mem, n, z;
      md = op[5:3];
      rg = op[2:0];
      sz = op[7:6];
      mem = (md >= M_IND && md <= M_IDX) || (md == M_EXT && rg <= R_ABS_L);
      treg = (md == M_DREG);
      a = src;
      nw = 2'h0;
      msk = 10'h3FF;
      if (op[15:12] == OR_LINE)
      begin
         sz = op[7:6];
         treg = !op[8];
         ok = (sz != SZ_BAD) && (treg ? (md != M_AREG && !(md == M_EXT && rg > R_IMM)) : mem);
         msk = 10'h3FF;
      end
      else
         ok = (op[15:8] == ORI_HIGH || op[15:8] == NOT_HIGH) && sz != SZ_BAD && (mem || md == M_DREG);
      imm = (sz == SZ_BYTE) ? {24'h0, ext[23:16]} : (sz == SZ_WORD) ? {16'h0, ext[31:16]} : ext;
      if (op[15:8] == ORI_HIGH || (treg && md == M_EXT && rg == R_IMM))
      begin
         a = imm;
         nw = (sz == SZ_LONG) ? 2'h2 : 2'h1;
      end
      r = (op[15:8] == NOT_HIGH) ? ~dst : (a | dst);
      res = (sz == SZ_BYTE) ? {dst[31:8], r[7:0]} : (sz == SZ_WORD) ? {dst[31:16], r[15:0]} : r;
      n = (sz == SZ_BYTE) ? r[7] : (sz == SZ_WORD) ? r[15] : r[31];
      z = (sz == SZ_BYTE) ? (r[7:0] == 8'h0) : (sz == SZ_WORD) ? (r[15:0] == 16'h0) : (r == 32'h0);
      cc = ok ? {ci[4], n, z, 2'b00} : ci;
      st = {nw, sz, op[11:9], treg, !ok, 1'b1};
      if (!ok)
      begin
         res = last;
         msk = 10'h003;
      end
   endfunction

   // ************************************************
   // main sequence
   // ************************************************
   initial
   begin
      logic [31:0] v, er, last;
      logic [1:0]  r;
      logic [4:0]  ec;
      logic [9:0]  es, em;
      failures = 0;
      check_count = 0;
      aresetn = 1'b0;
      awaddr = '0;
      araddr = '0;
      wdata = 32'h0;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      pm_idx = 5'h00;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      // every register reads zero after reset, including the execute control
      for (int k = 0; k < 8; k++)
      begin
         rd(ad(k[5:0]), v, r);
         chk("reset value", 32'h0, v);
         chk("reset answer", {30'h0, RESP_OK}, {30'h0, r});
      end
      wr(ad(IDX_STATUS), 32'hFFFF_FFFF, r);
      chk("read-only write answer", {30'h0, RESP_OK}, {30'h0, r});
      rd(ad(IDX_STATUS), v, r);
      chk("read-only unchanged", 32'h0, v);
      wr(8'h20, 32'h1, r);
      chk("unmapped write answer", {30'h0, RESP_ERR}, {30'h0, r});
      rd(8'hFC, v, r);
      chk("unmapped read data", 32'h0, v);
      chk("unmapped read answer", {30'h0, RESP_ERR}, {30'h0, r});
      $display("test registers done");
      // one program slot per case: load, execute, poll done, compare
      last = 32'h0;
      for (int i = 0; i < N; i++)
      begin
         pm_idx <= i[4:0];
         @(posedge aclk);
         wr(ad(IDX_OPWORD), {16'h0, pm_op}, r);
         wr(ad(IDX_EXT), pm_ext, r);
         wr(ad(IDX_SRC), SRCS[i], r);
         wr(ad(IDX_DST), DSTS[i], r);
         wr(ad(IDX_CCR), {27'h0, CCRS[i]}, r);
         wr(ad(IDX_CTRL), 32'h1, r);
         v = 32'h0;
         for (int p = 0; p < 10 && v[ST_DONE] !== 1'b1; p++)
            rd(ad(IDX_STATUS), v, r);
         model(pm_op, pm_ext, SRCS[i], DSTS[i], last, CCRS[i], er, ec, es, em);
         chk("status", {22'h0, es & em}, v & {22'h0, em}); // decode
         rd(ad(IDX_RESULT), v, r);
         chk("result", er, v); // merged value
         rd(ad(IDX_CCR), v, r);
         chk("flags", {27'h0, ec}, v); // condition codes
         last = er;
         $display("test case %0d done", i);
      end
      test_done();
   end
endmodule // tb_logical_or_decode_execute

// [hw/lod_core.sv]
// decode and execution of the inclusive-or, or-immediate and ones-complement operations
//
// Our own choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// What this block does
// RULE1 - register/memory or combines source and destination at byte, word or long
// RULE2 - an address_register is never accepted as either or operand
// RULE3 - after or: X kept, N from top bit, Z on zero, V and C cleared
// RULE4 - bits 11-9 name the data_register; opmode picks size and destination side
// RULE5 - or source effective address accepts data modes only, immediate included
// RULE6 - or destination effective address accepts memory alterable modes only
// RULE7 - software encodes data_register destinations with the register-destination opmode
// RULE8 - or_with_immediate_instruction ors the immediate into the destination at operation size
// RULE9 - or_with_immediate_instruction has bits 15-8 zero; bits 7-6 give the size
// RULE10 - immediate or and complement accept only data alterable destinations
// RULE11 - immediate comes from following words: low byte, one word, or two words
// RULE12 - complement inverts the destination; flags as for or
// RULE13 - size 11 or an excluded mode is reported as illegal instruction
// RULE14 - byte or word register destinations keep the untouched upper register bits
module lod_core
   import lod_pkg::*;
(
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready
);

   // ****************************************************
   // helpers
   // ****************************************************

   // mask of the bits an operation of the given size touches
   function automatic logic [31:0] size_mask(input logic [1:0] sz);
      case (sz)
         SZ_BYTE: size_mask = 32'h0000_00FF;
         SZ_WORD: size_mask = 32'h0000_FFFF;
         default: size_mask = 32'hFFFF_FFFF;
      endcase
   endfunction

   // sign bit of a value at the given size
   function automatic logic top_bit(input logic [31:0] v, input logic [1:0] sz);
      case (sz)
         SZ_BYTE: top_bit = v[7];
         SZ_WORD: top_bit = v[15];
         default: top_bit = v[31];
      endcase
   endfunction

   // byte-lane merge of a bus write
   function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] d,
                                              input logic [3:0] be);
      for (int i = 0; i < 4; i++)
         lane_merge[8*i +: 8] = be[i] ? d[8*i +: 8] : old[8*i +: 8];
   endfunction

   lod_state_s st;
   lod_state_s next_st;

   // decode of the held operation word
   lod_kind_e   d_kind;
   logic [1:0]  d_size;
   logic [2:0]  d_mode;
   logic [2:0]  d_reg;
   logic        d_to_reg;
   logic        d_legal;
   logic        d_imm_src;
   logic        d_memalt;
   logic        d_dalt;
   logic        d_datasrc;
   logic [31:0] d_imm;
   logic [31:0] d_raw;
   logic [31:0] d_result;

   // ****************************************************
   // decode and arithmetic
   // ****************************************************

   // mode legality and operation selection
   always_comb
   begin
      d_mode    = st.opword[5:3];
      d_reg     = st.opword[2:0];
      d_size    = st.opword[7:6];
      d_to_reg  = 1'b0;
      // RULE6 memory alterable set
      d_memalt  = (d_mode >= M_IND && d_mode <= M_IDX) || (d_mode == M_EXT && d_reg <= R_ABS_L);
      // RULE10 data alterable adds data_register direct only
      d_dalt    = (d_mode == M_DREG) || d_memalt;
      // RULE5 data modes: all but address_register direct and unused mode 7 codes
      d_datasrc = (d_mode != M_AREG) && (d_mode != M_EXT || d_reg <= R_IMM);
      d_imm_src = 1'b0;
      d_kind    = K_NONE;
      d_legal   = 1'b0;
      // RULE4 opmode bit 8 picks the side, bits 7-6 the size
      if (st.opword[15:12] == OR_LINE && d_size != SZ_BAD)
      begin
         d_kind    = K_OR;
         d_to_reg  = !st.opword[8];
         // RULE2 address_register refused on both sides
         d_legal   = d_to_reg ? d_datasrc : d_memalt;
         d_imm_src = d_to_reg && d_mode == M_EXT && d_reg == R_IMM;
      end
      // RULE9 immediate form recognised by a zero upper byte
      else if (st.opword[15:8] == ORI_HIGH && d_size != SZ_BAD)
      begin
         d_kind    = K_ORI;
         d_legal   = d_dalt;
         d_imm_src = 1'b1;
         d_to_reg  = d_mode == M_DREG;
      end
      else if (st.opword[15:8] == NOT_HIGH && d_size != SZ_BAD)
      begin
         d_kind   = K_NOT;
         d_legal  = d_dalt;
         d_to_reg = d_mode == M_DREG;
      end
   end

   // operand selection and result; at byte and word size the upper bits come from the old destination
   always_comb
   begin
      // RULE11 byte is the low byte of the first word, long spans both words
      case (d_size)
         SZ_BYTE: d_imm = {24'h00_0000, st.ext[23:16]};
         SZ_WORD: d_imm = {16'h0000, st.ext[31:16]};
         default: d_imm = st.ext;
      endcase
      case (d_kind)
         // RULE1 or of source and destination
         K_OR:    d_raw = (d_imm_src ? d_imm : st.src) | st.dst;
         // RULE8 immediate ored into destination
         K_ORI:   d_raw = d_imm | st.dst;
         // RULE12 ones complement of destination
         K_NOT:   d_raw = ~st.dst;
         default: d_raw = st.dst;
      endcase
      // RULE14 only the sized low part is replaced
      d_result = (d_raw & size_mask(d_size)) | (st.dst & ~size_mask(d_size));
   end

   // ****************************************************
   // bus slave and execution
   // ****************************************************

   // next state: bus writes first, execution results override them
   always_comb
   begin
      logic              aw_ok;
      logic              w_ok;
      logic [ADDR_W-1:0] wa;
      logic [31:0]       wd;
      logic [3:0]        ws;
      logic [31:0]       merged;
      aw_ok   = 1'b0;
      w_ok    = 1'b0;
      wa      = '0;
      wd      = '0;
      ws      = '0;
      merged  = '0;
      next_st = st;
      next_st.go = 1'b0;
      // address and data are taken in either order and held until both are in
      if (s_axi_awvalid && st.awready)
      begin
         next_st.aw_have = 1'b1;
         next_st.awaddr  = s_axi_awaddr;
      end
      if (s_axi_wvalid && st.wready)
      begin
         next_st.w_have = 1'b1;
         next_st.wdata  = s_axi_wdata;
         next_st.wstrb  = s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready)
         next_st.bvalid = 1'b0;
      aw_ok = next_st.aw_have;
      w_ok  = next_st.w_have;
      wa    = next_st.awaddr;
      wd    = next_st.wdata;
      ws    = next_st.wstrb;
      if (aw_ok && w_ok && !next_st.bvalid)
      begin
         next_st.aw_have = 1'b0;
         next_st.w_have  = 1'b0;
         next_st.bvalid  = 1'b1;
         next_st.bresp   = RESP_OK;
         case (wa[ADDR_W-1:2])
            // narrow registers merge through a full word, then keep their own bits
            IDX_OPWORD:
            begin
               merged         = lane_merge({16'h0000, st.opword}, wd, ws);
               next_st.opword = merged[15:0];
            end
            IDX_EXT:    next_st.ext    = lane_merge(st.ext, wd, ws);
            IDX_SRC:    next_st.src    = lane_merge(st.src, wd, ws);
            IDX_DST:    next_st.dst    = lane_merge(st.dst, wd, ws);
            IDX_CCR:
            begin
               merged      = lane_merge({27'h0, st.ccr}, wd, ws);
               next_st.ccr = merged[4:0];
            end
            IDX_CTRL:
            begin
               next_st.go   = wd[CTRL_GO] && ws[0];
               next_st.done = next_st.go ? 1'b0 : st.done;
            end
            IDX_RESULT, IDX_STATUS: ;   // read only, write ignored
            default:    next_st.bresp  = RESP_ERR;
         endcase
      end
      next_st.awready = !next_st.aw_have && !next_st.bvalid;
      next_st.wready  = !next_st.w_have && !next_st.bvalid;
      // read channel: one read at a time, answer held until rready
      if (s_axi_rvalid && s_axi_rready)
         next_st.rvalid = 1'b0;
      if (s_axi_arvalid && st.arready)
      begin
         next_st.rvalid = 1'b1;
         next_st.rresp  = RESP_OK;
         case (s_axi_araddr[ADDR_W-1:2])
            IDX_OPWORD: next_st.rdata = {16'h0000, st.opword};
            IDX_EXT:    next_st.rdata = st.ext;
            IDX_SRC:    next_st.rdata = st.src;
            IDX_DST:    next_st.rdata = st.dst;
            IDX_CTRL:   next_st.rdata = 32'h0000_0000;
            IDX_CCR:    next_st.rdata = {27'h000_0000, st.ccr};
            IDX_RESULT: next_st.rdata = st.result;
            IDX_STATUS: next_st.rdata = {22'h00_0000, st.nwords, st.size, st.dreg,
                                         st.to_reg, st.illegal, st.done};
            default:
            begin
               next_st.rdata = 32'h0000_0000;
               next_st.rresp = RESP_ERR;
            end
         endcase
      end
      next_st.arready = !next_st.rvalid;
      // execution one cycle after the go write; done is set here and wins over software
      if (st.go)
      begin
         next_st.done    = 1'b1;
         // RULE13 anything outside the three forms is flagged; status fields update, result and ccr keep their values
         next_st.illegal = !d_legal;
         next_st.size    = d_size;
         next_st.dreg    = st.opword[11:9];
         next_st.to_reg  = d_to_reg;
         next_st.nwords  = !d_imm_src ? 2'h0 : (d_size == SZ_LONG ? 2'h2 : 2'h1);
         if (d_legal)
         begin
            next_st.result = d_result;
            // RULE3 flags: X kept, V and C cleared
            next_st.ccr    = {st.ccr[4], top_bit(d_result, d_size),
                              (d_result & size_mask(d_size)) == 32'h0000_0000, 2'h0};
         end
      end
   end

   // single register for the whole state
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         st <= ST_RESET;
      else
         st <= next_st;
   end

   assign s_axi_awready = st.awready;
   assign s_axi_wready  = st.wready;
   assign s_axi_bvalid  = st.bvalid;
   assign s_axi_bresp   = st.bresp;
   assign s_axi_arready = st.arready;
   assign s_axi_rvalid  = st.rvalid;
   assign s_axi_rdata   = st.rdata;
   assign s_axi_rresp   = st.rresp;

   // ****************************************************
   // checks
   // ****************************************************
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   logic ex_ok;
   assign ex_ok = st.go && d_legal;

   // RULE1 memory-destination long or
   or_long_value_a: assert property (ex_ok && d_kind == K_OR && st.opword[8:6] == 3'h6 // RULE1
      |=> st.result == ($past(st.src) | $past(st.dst)))
      else $error("or long result wrong");
   // RULE2 address_register operand refused
   areg_refused_a: assert property (st.go && st.opword[15:12] == OR_LINE && d_mode == M_AREG // RULE2
      |=> st.illegal && st.done)
      else $error("address register operand accepted");
   // RULE3 flags after a legal execution
   flag_update_a: assert property (ex_ok |=> st.ccr[1:0] == 2'h0 && st.ccr[4] == $past(st.ccr[4]) // RULE3
      && st.ccr[2] == ((st.result & size_mask(st.size)) == 32'h0000_0000))
      else $error("condition flags wrong");
   // RULE4 register field and side
   reg_field_a: assert property (ex_ok && d_kind == K_OR // RULE4
      |=> st.dreg == $past(st.opword[11:9]) && st.to_reg == !$past(st.opword[8]))
      else $error("register field or side wrong");
   // RULE5 unused mode 7 source code refused
   src_modes_a: assert property (st.go && d_kind == K_OR && d_to_reg && d_mode == M_EXT // RULE5
      && d_reg > R_IMM |=> st.illegal)
      else $error("bad source mode accepted");
   // RULE6 pc-relative destination refused
   dst_modes_a: assert property (st.go && d_kind == K_OR && !d_to_reg && d_mode == M_EXT // RULE6
      && d_reg > R_ABS_L |=> st.illegal)
      else $error("bad destination mode accepted");
   // RULE8 byte immediate or
   imm_byte_a: assert property (ex_ok && d_kind == K_ORI && d_size == SZ_BYTE // RULE8
      |=> st.result[7:0] == ($past(st.ext[23:16]) | $past(st.dst[7:0])) && st.nwords == 2'h1)
      else $error("byte immediate or wrong");
   // RULE9 size 11 is not an immediate or
   size_bad_a: assert property (st.go && st.opword[15:8] == ORI_HIGH && d_size == SZ_BAD // RULE9
      |=> st.illegal ##1 st.illegal [*2])
      else $error("size 11 accepted");
   // RULE10 address_register destination of complement refused
   not_areg_a: assert property (st.go && st.opword[15:8] == NOT_HIGH && d_mode == M_AREG // RULE10
      |=> st.illegal)
      else $error("complement of address register accepted");
   // RULE11 long immediate takes two words
   imm_long_a: assert property (ex_ok && d_kind == K_ORI && d_size == SZ_LONG // RULE11
      |=> st.nwords == 2'h2 && st.result == ($past(st.ext) | $past(st.dst)))
      else $error("long immediate wrong");
   // RULE12 word complement
   not_word_a: assert property (ex_ok && d_kind == K_NOT && d_size == SZ_WORD // RULE12
      |=> st.result[15:0] == ~$past(st.dst[15:0]))
      else $error("complement wrong");
   // RULE14 upper bits of byte register destination kept
   upper_kept_a: assert property (ex_ok && d_to_reg && d_size == SZ_BYTE // RULE14
      |=> st.result[31:8] == $past(st.dst[31:8]))
      else $error("upper register bits changed");

   or_reg_c: cover property (ex_ok && d_kind == K_OR && d_to_reg);
   ori_long_c: cover property (ex_ok && d_kind == K_ORI && d_size == SZ_LONG);
   not_illegal_c: cover property (st.go && d_kind == K_NOT && !d_legal);
   write_read_c: cover property (st.bvalid ##[1:4] st.rvalid);

endmodule // lod_core

// [hw/lod_pkg.sv]
// shared constants, register map and state layout of the logical-or decode/execute block
package lod_pkg;

   // ****************************************************
   // register map (word indices; the AXI4-Lite byte address is four times the index)
   // ****************************************************
   localparam int unsigned ADDR_W     = 8;
   localparam logic [5:0]  IDX_OPWORD = 6'h00;  // operation word, low 16 bits
   localparam logic [5:0]  IDX_EXT    = 6'h01;  // first extension word [31:16], second [15:0]
   localparam logic [5:0]  IDX_SRC    = 6'h02;  // source operand fetched by the bus unit
   localparam logic [5:0]  IDX_DST    = 6'h03;  // destination operand (register or memory value)
   localparam logic [5:0]  IDX_CTRL   = 6'h04;  // write bit 0 to execute, reads zero
   localparam logic [5:0]  IDX_CCR    = 6'h05;  // condition codes X N Z V C in bits 4..0
   localparam logic [5:0]  IDX_RESULT = 6'h06;  // value to write back to the destination
   localparam logic [5:0]  IDX_STATUS = 6'h07;  // decode outcome, read only

   // status field positions
   localparam int unsigned ST_DONE    = 0;
   localparam int unsigned ST_ILLEGAL = 1;
   localparam int unsigned ST_TO_REG  = 2;
   localparam int unsigned ST_DREG    = 3;      // 3 bits
   localparam int unsigned ST_SIZE    = 6;      // 2 bits
   localparam int unsigned ST_NWORDS  = 8;      // 2 bits
   localparam int unsigned CTRL_GO    = 0;

   // ****************************************************
   // instruction encodings
   // ****************************************************
   localparam logic [3:0] OR_LINE   = 4'hC;     // bits 15-12 of register/memory or
   localparam logic [7:0] ORI_HIGH  = 8'h00;    // bits 15-8 of or_with_immediate_instruction
   localparam logic [7:0] NOT_HIGH  = 8'h46;    // bits 15-8 of ones complement
   localparam logic [1:0] SZ_BYTE   = 2'h0;
   localparam logic [1:0] SZ_WORD   = 2'h1;
   localparam logic [1:0] SZ_LONG   = 2'h2;
   localparam logic [1:0] SZ_BAD    = 2'h3;
   localparam logic [2:0] M_DREG    = 3'h0;     // data_register direct
   localparam logic [2:0] M_AREG    = 3'h1;     // address_register direct
   localparam logic [2:0] M_IND     = 3'h2;     // lowest indirect mode
   localparam logic [2:0] M_IDX     = 3'h6;     // highest address-register based mode
   localparam logic [2:0] M_EXT     = 3'h7;     // absolute, pc-relative, immediate
   localparam logic [2:0] R_ABS_L   = 3'h1;     // last absolute register code
   localparam logic [2:0] R_IMM     = 3'h4;     // immediate register code
   localparam logic [1:0] RESP_OK   = 2'h0;
   localparam logic [1:0] RESP_ERR  = 2'h2;

   typedef enum logic [1:0] {K_NONE, K_OR, K_ORI, K_NOT} lod_kind_e;

   // ****************************************************
   // whole state of the block
   // ****************************************************
   typedef struct packed {
      logic [15:0]       opword;
      logic [31:0]       ext;
      logic [31:0]       src;
      logic [31:0]       dst;
      logic [4:0]        ccr;
      logic [31:0]       result;
      logic              done;
      logic              illegal;
      logic              to_reg;
      logic [2:0]        dreg;
      logic [1:0]        size;
      logic [1:0]        nwords;
      logic              go;
      logic              aw_have;
      logic [ADDR_W-1:0] awaddr;
      logic              w_have;
      logic [31:0]       wdata;
      logic [3:0]        wstrb;
      logic              awready;
      logic              wready;
      logic              bvalid;
      logic [1:0]        bresp;
      logic              arready;
      logic              rvalid;
      logic [31:0]       rdata;
      logic [1:0]        rresp;
   } lod_state_s;

   localparam lod_state_s ST_RESET = '{awready: 1'b1, wready: 1'b1, arready: 1'b1, default: '0};

endpackage
